// >>> obt_pkg.sv
// Shared constants and types for the ordinary-space bus timing block.
`default_nettype none
package obt_pkg;
    localparam int          NSPACE        = 4;
    localparam int          APB_AW        = 12;
    localparam int          CFG_W         = 16;
    localparam int          DATA_W        = 16;

    // Register byte offsets on the APB side.
    localparam logic [11:0] OFF_AREA_WAIT = 12'h000;
    localparam logic [11:0] OFF_BUS_IDLE  = 12'h004;

    // Reset values and the bits of the wait register that always read one.
    localparam logic [15:0] AREA_WAIT_RST = 16'hffff;
    localparam logic [15:0] BUS_IDLE_RST  = 16'hffff;
    localparam logic [15:0] AREA_WAIT_RSV = 16'hcccc;

    // Field positions: wait field at SPACE_STRIDE*n, idle-after-read at IDLE_RD_LSB+2n,
    // continuous idle at CONT_IDLE_LSB+n, select extension at SEL_EXT_LSB+n.
    localparam int          SPACE_STRIDE  = 4;
    localparam int          IDLE_RD_LSB   = 8;
    localparam int          CONT_IDLE_LSB = 4;
    localparam int          SEL_EXT_LSB   = 0;

    localparam logic [1:0]  CNT_MAX       = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_GAP     = 3'b001,
        ST_SETUPX  = 3'b010,
        ST_FIRST   = 3'b011,
        ST_WAIT    = 3'b100,
        ST_SECOND  = 3'b101,
        ST_HOLDX   = 3'b110
    } obt_state_e;
endpackage
`default_nettype wire

// >>> obt_cfg_regs.sv
// APB register file holding the wait and bus idle configuration.
`default_nettype none
module obt_cfg_regs (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [obt_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic      [obt_pkg::CFG_W-1:0] areaWaitCfg,
    output logic      [obt_pkg::CFG_W-1:0] busIdleCfg
);
    import obt_pkg::*;

    logic [15:0] wait_ff, nxt_wait;
    logic [15:0] idle_ff, nxt_idle;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ready_ff, nxt_ready;
    logic        err_ff, nxt_err;
    logic        hitWait, hitIdle, access;

    assign hitWait     = paddr == OFF_AREA_WAIT;
    assign hitIdle     = paddr == OFF_BUS_IDLE;
    assign access      = psel && penable;
    assign prdata      = rdata_ff;
    assign pready      = ready_ff;
    assign pslverr     = err_ff;
    assign areaWaitCfg = wait_ff;
    assign busIdleCfg  = idle_ff;

    // One wait cycle keeps read data and the answer coming straight from flip-flops.
    always_comb begin
        nxt_wait  = wait_ff;
        nxt_idle  = idle_ff;
        nxt_rdata = rdata_ff;
        nxt_ready = 1'b0;
        nxt_err   = 1'b0;
        if (access && !ready_ff) begin
            nxt_ready = 1'b1;
            nxt_err   = !(hitWait || hitIdle);
            if (hitWait) begin
                nxt_rdata = {16'h0000, wait_ff | AREA_WAIT_RSV};
            end else if (hitIdle) begin
                nxt_rdata = {16'h0000, idle_ff};
            end else begin
                nxt_rdata = 32'h00000000;
            end
        end
        if (access && ready_ff && pwrite) begin
            if (hitWait) begin
                nxt_wait = pwdata[15:0] | AREA_WAIT_RSV;
            end
            if (hitIdle) begin
                nxt_idle = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_ff  <= AREA_WAIT_RST;
            idle_ff  <= BUS_IDLE_RST;
            rdata_ff <= 32'h00000000;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end else begin
            wait_ff  <= nxt_wait;
            idle_ff  <= nxt_idle;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff   <= nxt_err;
        end
    end
endmodule
`default_nettype wire

// >>> obt_bus_timing.sv
// Ordinary-space external bus sequencer with wait, extension and idle insertion.
//
// Overview of operation
// - Wait register resets to all ones.
// - Reserved wait register bits read one.
// - Wait code zero ignores wait pin.
// - Wait fields sit at fixed positions.
// - Plain cycle takes exactly two states.
// - Read captures full width, keeps needed lanes.
// - Byte write strobes follow used lanes.
// - Insert programmed zero to three waits.
// - Wait pin sampled only with software waits.
// - Wait pin sampled before last wait ends.
// - Extension adds one state each side.
// - Extension states drive select, no strobes.
// - Write data held through hold extension.
// - Idle after read before write/other space.
// - Only shortfall of idles is inserted.
// - Idle-after-read count zero to three.
// - Same-space back-to-back idles negate select.
// - Read then write uses larger count.
// - Existing idles cancel continuous idle.
// - Idle-after-read field layout and coding.
// - Continuous idle bit gives one idle.
// - Extension bit per space enables extension.
// - Idle register resets to all ones.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`default_nettype none
module obt_bus_timing #(
    parameter int ADDR_W = 20
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [obt_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        reqValid,
    input  wire logic                        reqWrite,
    input  wire logic [1:0]                  reqSpace,
    input  wire logic [ADDR_W-1:0]           reqAddr,
    input  wire logic [1:0]                  reqBe,
    input  wire logic [obt_pkg::DATA_W-1:0]  reqWdata,
    output logic                             reqAck,
    output logic                             rdValid,
    output logic      [obt_pkg::DATA_W-1:0]  rdData,
    output logic      [obt_pkg::NSPACE-1:0]  areaSelectN,
    output logic                             readStrobeN,
    output logic                             writeStrobeHighN,
    output logic                             writeStrobeLowN,
    output logic      [ADDR_W-1:0]           extAddr,
    output logic      [obt_pkg::DATA_W-1:0]  dataOut,
    output logic                             dataOe,
    input  wire logic [obt_pkg::DATA_W-1:0]  dataIn,
    input  wire logic                        waitN
);
    import obt_pkg::*;

    logic [1:0]  rstPipe_ff;
    logic        rstnSync;
    logic [15:0] areaWaitCfg, busIdleCfg;

    // Per-space decoded settings.
    logic [1:0]  waitSel  [NSPACE];
    logic [1:0]  idleRd   [NSPACE];
    logic        contIdle [NSPACE];
    logic        selExt   [NSPACE];

    obt_state_e        state_ff, nxt_state;
    logic [1:0]        cnt_ff, nxt_cnt;
    logic [1:0]        gap_ff, nxt_gap;
    logic              curWrite_ff, nxt_curWrite;
    logic [1:0]        curSpace_ff, nxt_curSpace;
    logic [ADDR_W-1:0] curAddr_ff, nxt_curAddr;
    logic [1:0]        curBe_ff, nxt_curBe;
    logic [15:0]       curWdata_ff, nxt_curWdata;
    logic              prevRead_ff, nxt_prevRead;
    logic              prevValid_ff, nxt_prevValid;
    logic [1:0]        prevSpace_ff, nxt_prevSpace;
    logic              ack_ff, nxt_ack;
    logic              rdv_ff, nxt_rdv;
    logic [15:0]       rdd_ff, nxt_rdd;
    logic [3:0]        cs_ff, nxt_cs;
    logic              rd_ff, nxt_rd;
    logic              wrh_ff, nxt_wrh;
    logic              wrl_ff, nxt_wrl;
    logic              oe_ff, nxt_oe;
    logic              waitPin_ff, nxt_waitPin;

    logic              canTake, take, curExt;
    logic [1:0]        curWait, need, seen, extra;
    logic [15:0]       laneMask;
    logic              pValid, pRead;
    logic [1:0]        pSpace;

    // The reset is released through two flip-flops so that no register leaves reset on a ragged edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstnSync = rstPipe_ff[1];

    obt_cfg_regs u_regs (
        .clk         (clk),
        .rstn        (rstnSync),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .areaWaitCfg (areaWaitCfg),
        .busIdleCfg  (busIdleCfg)
    );

    for (genvar s = 0; s < NSPACE; s++) begin : g_space
        assign waitSel[s]  = areaWaitCfg[SPACE_STRIDE*s +: 2];
        assign idleRd[s]   = busIdleCfg[IDLE_RD_LSB + 2*s +: 2];
        assign contIdle[s] = busIdleCfg[CONT_IDLE_LSB + s];
        assign selExt[s]   = busIdleCfg[SEL_EXT_LSB + s];
    end

    // Settings of the access in flight come from its own space.
    assign curWait = waitSel[curSpace_ff];
    assign curExt  = selExt[curSpace_ff];

    // A new request may be taken in idle, at the second state when the space has no extension, or at the hold extension.
    assign canTake = (state_ff == ST_IDLE) || (state_ff == ST_HOLDX) || (state_ff == ST_SECOND && !curExt);
    assign take    = canTake && reqValid && !ack_ff;
    assign seen    = (state_ff == ST_IDLE) ? ((gap_ff == CNT_MAX) ? CNT_MAX : gap_ff + 2'h1) : 2'h0;

    // Idles needed before the next access follow the previous access's space.
    always_comb begin
        pValid = prevValid_ff;
        pRead  = prevRead_ff;
        pSpace = prevSpace_ff;
        // A request taken at the second state follows the access still on the bus, not the one before it.
        if (state_ff == ST_SECOND) begin
            pValid = 1'b1;
            pRead  = !curWrite_ff;
            pSpace = curSpace_ff;
        end
        need = 2'h0;
        if (pValid) begin
            if (pRead && (reqWrite || reqSpace != pSpace)) begin
                need = idleRd[pSpace];
            end
            if (reqSpace == pSpace && contIdle[pSpace] && seen == 2'h0) begin
                if (need == 2'h0) begin
                    need = 2'h1;
                end
            end
        end
        extra = (need > seen) ? need - seen : 2'h0;
    end

    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_gap       = gap_ff;
        nxt_curWrite  = curWrite_ff;
        nxt_curSpace  = curSpace_ff;
        nxt_curAddr   = curAddr_ff;
        nxt_curBe     = curBe_ff;
        nxt_curWdata  = curWdata_ff;
        nxt_prevRead  = prevRead_ff;
        nxt_prevValid = prevValid_ff;
        nxt_prevSpace = prevSpace_ff;
        nxt_ack       = take;
        nxt_rdv       = 1'b0;
        nxt_rdd       = rdd_ff;
        nxt_waitPin   = waitN;
        case (state_ff)
            ST_IDLE: begin
                nxt_gap = seen;
            end
            ST_GAP: begin
                if (cnt_ff <= 2'h1) begin
                    nxt_state = selExt[curSpace_ff] ? ST_SETUPX : ST_FIRST;
                end else begin
                    nxt_cnt = cnt_ff - 2'h1;
                end
            end
            ST_SETUPX: begin
                nxt_state = ST_FIRST;
            end
            ST_FIRST: begin
                nxt_cnt = curWait;
                if (curWait == 2'h0) begin
                    nxt_state = ST_SECOND;
                end else begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_ff > 2'h1) begin
                    nxt_cnt = cnt_ff - 2'h1;
                end else if (waitPin_ff) begin
                    // The pin was taken one edge ahead, so the device gets a full cycle to answer.
                    nxt_state = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (!curWrite_ff) begin
                    nxt_rdv = 1'b1;
                    nxt_rdd = dataIn & laneMask;
                end
                nxt_prevValid = 1'b1;
                nxt_prevRead  = !curWrite_ff;
                nxt_prevSpace = curSpace_ff;
                if (curExt) begin
                    nxt_state = ST_HOLDX;
                end else begin
                    nxt_state = ST_IDLE;
                    nxt_gap   = 2'h0;
                end
            end
            ST_HOLDX: begin
                nxt_state = ST_IDLE;
                nxt_gap   = 2'h0;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (take) begin
            nxt_curWrite = reqWrite;
            nxt_curSpace = reqSpace;
            nxt_curAddr  = reqAddr;
            nxt_curBe    = reqBe;
            nxt_curWdata = reqWdata;
            nxt_cnt      = extra;
            if (extra != 2'h0) begin
                nxt_state = ST_GAP;
            end else begin
                nxt_state = selExt[reqSpace] ? ST_SETUPX : ST_FIRST;
            end
        end
    end

    assign laneMask = {{8{curBe_ff[1]}}, {8{curBe_ff[0]}}};

    // Pins are decoded from the next state so they change with the state, not a cycle late.
    always_comb begin
        nxt_cs  = 4'hf;
        nxt_rd  = 1'b1;
        nxt_wrh = 1'b1;
        nxt_wrl = 1'b1;
        nxt_oe  = 1'b0;
        if (nxt_state != ST_IDLE && nxt_state != ST_GAP) begin
            nxt_cs = ~(4'h1 << nxt_curSpace);
        end
        if (nxt_state == ST_FIRST || nxt_state == ST_WAIT || nxt_state == ST_SECOND) begin
            nxt_rd  = nxt_curWrite;
            nxt_wrh = !(nxt_curWrite && nxt_curBe[1]);
            nxt_wrl = !(nxt_curWrite && nxt_curBe[0]);
            nxt_oe  = nxt_curWrite;
        end
        if (nxt_state == ST_HOLDX) begin
            nxt_oe = nxt_curWrite;
        end
    end

    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 2'h0;
            gap_ff       <= CNT_MAX;
            curWrite_ff  <= 1'b0;
            curSpace_ff  <= 2'h0;
            curAddr_ff   <= '0;
            curBe_ff     <= 2'h0;
            curWdata_ff  <= 16'h0000;
            prevRead_ff  <= 1'b0;
            prevValid_ff <= 1'b0;
            prevSpace_ff <= 2'h0;
            ack_ff       <= 1'b0;
            rdv_ff       <= 1'b0;
            rdd_ff       <= 16'h0000;
            cs_ff        <= 4'hf;
            rd_ff        <= 1'b1;
            wrh_ff       <= 1'b1;
            wrl_ff       <= 1'b1;
            oe_ff        <= 1'b0;
            waitPin_ff   <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            gap_ff       <= nxt_gap;
            curWrite_ff  <= nxt_curWrite;
            curSpace_ff  <= nxt_curSpace;
            curAddr_ff   <= nxt_curAddr;
            curBe_ff     <= nxt_curBe;
            curWdata_ff  <= nxt_curWdata;
            prevRead_ff  <= nxt_prevRead;
            prevValid_ff <= nxt_prevValid;
            prevSpace_ff <= nxt_prevSpace;
            ack_ff       <= nxt_ack;
            rdv_ff       <= nxt_rdv;
            rdd_ff       <= nxt_rdd;
            cs_ff        <= nxt_cs;
            rd_ff        <= nxt_rd;
            wrh_ff       <= nxt_wrh;
            wrl_ff       <= nxt_wrl;
            oe_ff        <= nxt_oe;
            waitPin_ff   <= nxt_waitPin;
        end
    end

    assign reqAck           = ack_ff;
    assign rdValid          = rdv_ff;
    assign rdData           = rdd_ff;
    assign areaSelectN      = cs_ff;
    assign readStrobeN      = rd_ff;
    assign writeStrobeHighN = wrh_ff;
    assign writeStrobeLowN  = wrl_ff;
    assign extAddr          = curAddr_ff;
    assign dataOut          = curWdata_ff;
    assign dataOe           = oe_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstnSync);

    cfg_reset_a: assert property ($rose(rstnSync) |-> areaWaitCfg == 16'hffff && busIdleCfg == 16'hffff)
        else $error("Configuration registers not all ones after reset.");
    rsv_ones_a: assert property ((areaWaitCfg & 16'hcccc) == 16'hcccc)
        else $error("Reserved wait register bits are not one.");
    two_state_a: assert property (state_ff == ST_FIRST && curWait == 2'h0 |=> state_ff == ST_SECOND)
        else $error("Zero-wait cycle did not end after two states.");
    wait_count_a: assert property (state_ff == ST_FIRST && curWait == 2'h3 |=> state_ff == ST_WAIT [*3])
        else $error("Fewer wait states than programmed.");
    wait_hold_a: assert property (state_ff == ST_WAIT && cnt_ff == 2'h1 && !$past(waitN)
        |=> state_ff == ST_WAIT)
        else $error("Wait state left while wait pin was low.");
    wait_end_a: assert property (state_ff == ST_WAIT && cnt_ff == 2'h1 && $past(waitN)
        |=> state_ff == ST_SECOND)
        else $error("Wait state not left after wait pin released.");
    ext_strobe_a: assert property ((state_ff == ST_SETUPX || state_ff == ST_HOLDX)
        |-> readStrobeN && writeStrobeHighN && writeStrobeLowN && areaSelectN != 4'hf)
        else $error("Strobe active in an extension state.");
    ext_hold_a: assert property (state_ff == ST_SECOND && curExt |=> state_ff == ST_HOLDX ##1 state_ff != ST_HOLDX)
        else $error("Hold extension missing or too long.");
    hold_data_a: assert property (state_ff == ST_HOLDX && curWrite_ff |-> dataOe)
        else $error("Write data released before hold extension ended.");
    lane_high_a: assert property (!writeStrobeHighN |-> curWrite_ff && curBe_ff[1])
        else $error("High write strobe without its byte lane.");
    gap_cs_a: assert property (state_ff == ST_GAP |-> areaSelectN == 4'hf)
        else $error("Area select active during an inserted idle.");
endmodule
`default_nettype wire

// >>> obt_sram_model.sv
// Behavioural external memory for the ordinary-space bus, with a programmable wait-pin stall.
`default_nettype none
module obt_sram_model #(
    parameter int ADDR_W = 20
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [3:0]        areaSelectN,
    input  wire logic              readStrobeN,
    input  wire logic              writeStrobeHighN,
    input  wire logic              writeStrobeLowN,
    input  wire logic [ADDR_W-1:0] extAddr,
    input  wire logic [15:0]       dataOut,
    input  wire logic              dataOe,
    input  wire logic [2:0]        stall,
    output logic      [15:0]       dataIn,
    output logic                   waitN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] lastBus_ff;
    logic [2:0]  strbCnt_ff;
    logic        selOn;
    logic        rdOn;
    logic        busy;
    assign selOn = !(&areaSelectN);
    assign rdOn  = selOn && !readStrobeN;
    assign busy  = rdOn || !writeStrobeHighN || !writeStrobeLowN;
    // A released bus shows the inverse of its last level, so stale data never passes for a read.
    assign dataIn = dataOe ? dataOut : (rdOn ? mem[extAddr[3:0]] : ~lastBus_ff);
    // The wait request is held low until the strobe has been active for stall cycles.
    assign waitN = !(busy && strbCnt_ff < stall);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strbCnt_ff <= 3'h0;
            lastBus_ff <= 16'h0;
        end else begin
            strbCnt_ff <= busy ? strbCnt_ff + 3'h1 : 3'h0;
            lastBus_ff <= dataIn;
            if (selOn && !writeStrobeHighN) begin
                mem[extAddr[3:0]][15:8] <= dataOut[15:8];
            end
            if (selOn && !writeStrobeLowN) begin
                mem[extAddr[3:0]][7:0] <= dataOut[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> obt_bus_timing_bench.sv
// Self-checking bench for the ordinary-space bus sequencer and its memory model.
`default_nettype none
module obt_bus_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import obt_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, g0;
    logic        reqValid, reqWrite, reqAck, rdValid, readStrobeN, writeStrobeHighN, writeStrobeLowN;
    logic        dataOe, waitN;
    logic [1:0]  reqSpace, reqBe;
    logic [19:0] reqAddr, extAddr;
    logic [15:0] reqWdata, rdData, dataOut, dataIn, lastRd, wv, d, msk, mexp;
    logic [3:0]  areaSelectN;
    logic [2:0]  stall;
    int          error_cnt, cmp_count, es, st;
    int          selCyc, strbCyc, oeCyc, whCyc, wlCyc, gapRun, lastGap;
    obt_bus_timing u_obt_bus_timing (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .reqValid, .reqWrite, .reqSpace, .reqAddr, .reqBe, .reqWdata,
        .reqAck, .rdValid, .rdData, .areaSelectN, .readStrobeN, .writeStrobeHighN, .writeStrobeLowN,
        .extAddr, .dataOut, .dataOe, .dataIn, .waitN);
    obt_sram_model u_obt_sram_model (.clk, .resetn, .areaSelectN, .readStrobeN, .writeStrobeHighN,
        .writeStrobeLowN, .extAddr, .dataOut, .dataOe, .stall, .dataIn, .waitN);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cycle counts are kept running; each transfer is judged by the change across it.
    always @(posedge clk) begin
        if (!(&areaSelectN)) begin
            selCyc <= selCyc + 1;
            if (gapRun > 0) lastGap <= gapRun;
            gapRun <= 0;
        end else gapRun <= gapRun + 1;
        if (!readStrobeN || !writeStrobeHighN || !writeStrobeLowN) strbCyc <= strbCyc + 1;
        if (dataOe) oeCyc <= oeCyc + 1;
        if (!writeStrobeHighN) whCyc <= whCyc + 1;
        if (!writeStrobeLowN) wlCyc <= wlCyc + 1;
        if (rdValid) lastRd <= rdData;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 20), 32'h1);
    endtask
    // With settle zero the request line stays up so the next call follows back to back.
    task automatic xfer(input logic wr, input logic [1:0] sp, be, input logic [15:0] wd, input int settle);
        int n;
        n = 0;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqSpace <= sp;
        reqBe <= be;
        reqAddr <= 20'(sp);
        reqWdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (reqAck !== 1'b1 && n < 40);
        if (settle > 0) begin
            reqValid <= 1'b0;
            // Inserted idles keep every select high, so first wait for the access itself.
            do begin
                @(negedge clk);
                n++;
            end while (&areaSelectN && n < 80);
            do begin
                @(negedge clk);
                n++;
            end while (!(&areaSelectN) && n < 80);
            repeat (settle) @(posedge clk);
        end
        chk(32'(n < 80), 32'h1);
    endtask
    task automatic single(input logic wr, input logic [1:0] sp, be, input logic [15:0] wd,
                          input int esel, et, eo, eh, el);
        int s0, t0, o0, h0, l0;
        s0 = selCyc;
        t0 = strbCyc;
        o0 = oeCyc;
        h0 = whCyc;
        l0 = wlCyc;
        xfer(wr, sp, be, wd, 3);
        chk(32'(selCyc - s0), 32'(esel));
        chk(32'(strbCyc - t0), 32'(et));
        chk(32'(oeCyc - o0), 32'(eo));
        chk(32'(whCyc - h0), 32'(eh));
        chk(32'(wlCyc - l0), 32'(el));
    endtask
    task automatic pair(input logic [15:0] bi, input logic w1, input logic [1:0] s1, input logic w2,
                        input logic [1:0] s2, input int dly, input int eg);
        apb(1'b1, OFF_BUS_IDLE, {16'h0, bi});
        xfer(w1, s1, 2'h3, 16'h0, dly);
        xfer(w2, s2, 2'h3, 16'h0, 3);
        rv = 32'(lastGap);
        if (eg >= 0) chk(rv, 32'(eg));
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqSpace = 2'h0;
        reqAddr = 20'h0;
        reqBe = 2'h0;
        reqWdata = 16'h0;
        stall = 3'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, OFF_AREA_WAIT, 32'h0);
        chk(rv, 32'(AREA_WAIT_RST));
        apb(1'b0, OFF_BUS_IDLE, 32'h0);
        chk(rv, 32'(BUS_IDLE_RST));
        apb(1'b0, 12'h008, 32'h0);
        chk({rv[31:1], errv}, 32'h1);
        single(1'b0, 2'h0, 2'h3, 16'h0, 7, 5, 0, 0, 0);
        apb(1'b1, OFF_BUS_IDLE, 32'h0);
        // Reserved wait bits are written as zero on purpose to see them read back as one.
        for (int sp = 0; sp < 4; sp++) begin
            for (int w = 0; w < 8; w++) begin
                wv = 16'(w % 4) << (SPACE_STRIDE * sp);
                apb(1'b1, OFF_AREA_WAIT, {16'h0, wv});
                apb(1'b0, OFF_AREA_WAIT, 32'h0);
                chk(rv, {16'h0, wv | AREA_WAIT_RSV});
                st = w < 4 ? 0 : 3;
                stall <= 3'(st);
                es = (w % 4 == 0) ? 2 : 2 + ((w % 4) > st ? (w % 4) : st + 1);
                single(1'b0, 2'(sp), 2'h3, 16'h0, es, es, 0, 0, 0);
            end
        end
        stall <= 3'h0;
        apb(1'b1, OFF_AREA_WAIT, 32'h0);
        mexp = 16'h1234;
        single(1'b1, 2'h1, 2'h3, mexp, 2, 2, 2, 2, 2);
        for (int b = 1; b < 4; b++) begin
            d = 16'h5a00 ^ 16'(b * 'h1111);
            msk = {{8{b[1]}}, {8{b[0]}}};
            mexp = (mexp & ~msk) | (d & msk);
            single(1'b1, 2'h1, 2'(b), d, 2, 2, 2, 2 * b[1], 2 * b[0]);
            single(1'b0, 2'h1, 2'h3, 16'h0, 2, 2, 0, 0, 0);
            chk(32'(lastRd), 32'(mexp));
            single(1'b0, 2'h1, 2'(b), 16'h0, 2, 2, 0, 0, 0);
            chk(32'(lastRd), 32'(mexp & msk));
        end
        apb(1'b1, OFF_BUS_IDLE, 32'hf);
        apb(1'b1, OFF_AREA_WAIT, 32'h1111);
        single(1'b1, 2'h3, 2'h3, 16'h0f0f, 5, 3, 4, 3, 3);
        single(1'b0, 2'h2, 2'h3, 16'h0, 5, 3, 0, 0, 0);
        apb(1'b1, OFF_AREA_WAIT, 32'h0);
        pair(16'h0200, 1'b0, 2'h0, 1'b0, 2'h1, 0, 2);
        pair(16'h0300, 1'b0, 2'h0, 1'b1, 2'h0, 0, 3);
        pair(16'h4000, 1'b0, 2'h3, 1'b0, 2'h2, 0, 1);
        pair(16'h0210, 1'b0, 2'h0, 1'b1, 2'h0, 0, 2);
        pair(16'h0010, 1'b0, 2'h0, 1'b1, 2'h0, 0, 1);
        pair(16'h0010, 1'b1, 2'h0, 1'b1, 2'h0, 0, 1);
        pair(16'h0000, 1'b0, 2'h0, 1'b0, 2'h1, 4, -1);
        g0 = rv;
        pair(16'h0300, 1'b0, 2'h0, 1'b0, 2'h1, 4, -1);
        chk(rv, g0);
        pair(16'h0000, 1'b1, 2'h0, 1'b1, 2'h0, 4, -1);
        g0 = rv;
        pair(16'h0010, 1'b1, 2'h0, 1'b1, 2'h0, 4, -1);
        chk(rv, g0);
        stop_test();
    end
endmodule
`default_nettype wire
